// ---- hw/scc_pkg.sv ----
// Overview of operation
// - a current trip resets the channel latch and switches that output off.
// - after a trip the output stays off until the next chop pulse sets it.
// - chop pulses go to two groups, even channels and odd channels.
// - with chop inhibit present, chopping stops and trips do not turn outputs off.
// - minimum on-time lockout per chop period.
// - trip to output-off latency is a few hundred nanoseconds at most.
// - over-temperature forces every output off regardless of everything else.
// - after thermal shutdown, outputs return only when the release indication asserts.
// - power-up reset holds every output off.
// - trips are ignored during a blanking interval after each output turn-on.
// - only latched-high channels drive, and only inside the print-enable window.
// - each channel is independent; a fixed-frequency chop pulse sets its latch.
`default_nettype none
package scc_pkg;
   localparam int unsigned CLK_MHZ = 100;
   // chop period: 100 kHz nominal
   localparam int unsigned CHOP_PERIOD_NS = 10000;
   localparam int unsigned CHOP_CYC = CHOP_PERIOD_NS * CLK_MHZ / 1000;
   // lockout: 15% of the chop period as least on time
   localparam int unsigned LOCKOUT_PCT = 15;
   localparam int unsigned LOCKOUT_CYC = (CHOP_CYC * LOCKOUT_PCT + 99) / 100;
   // blanking after turn-on
   localparam int unsigned BLANK_NS = 500;
   localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   // maximum trip to off latency, longest count rounds down
   localparam int unsigned TRIP_DELAY_NS = 300;
   localparam int unsigned TRIP_DELAY_CYC = (TRIP_DELAY_NS * CLK_MHZ) / 1000;
   // internal power-on hold
   localparam int unsigned POR_CYC = 16;
   localparam int unsigned CHANNELS = 9;
   localparam int unsigned CNT_W = 16;
endpackage
`default_nettype wire

// ---- hw/scc_chan.sv ----
`default_nettype none
// one channel: set/reset latch with blanking and lockout
module scc_chan
   import scc_pkg::*;
#(
   parameter int unsigned LOCK_W = 8
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic set_i,
   input wire logic trip_i,
   input wire logic allow_i,
   input wire logic inhibit_i,
   output logic drive_o
);
   logic on_r, on_nxt;
   logic [LOCK_W-1:0] age_r, age_nxt;
   logic blank, lock;

   // on-time age gates trip acceptance
   always_comb begin
      blank = (age_r < LOCK_W'(BLANK_CYC));
      lock = (age_r < LOCK_W'(LOCKOUT_CYC));
      on_nxt = on_r;
      age_nxt = age_r;
      if (on_r && !(&age_r)) begin
         age_nxt = age_r + LOCK_W'(1);
      end
      if (!allow_i) begin
         on_nxt = 1'b0;
      end else if (on_r) begin
         // inhibit keeps the output on for the whole window
         if (trip_i && !blank && !lock && !inhibit_i) begin
            on_nxt = 1'b0;
         end
      end else if (set_i || inhibit_i) begin
         on_nxt = 1'b1;
         age_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         on_r <= 1'b0;
         age_r <= '0;
      end else begin
         on_r <= on_nxt;
         age_r <= age_nxt;
      end
   end

   assign drive_o = on_r;
endmodule
`default_nettype wire

// ---- hw/scc_top.sv ----
`default_nettype none
// nine-channel chop current control
module scc_top
   import scc_pkg::*;
#(
   parameter int unsigned NCH = CHANNELS
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [NCH-1:0] latch_data_i,
   input wire logic print_en_i,
   input wire logic [NCH-1:0] trip_i,
   input wire logic chop_inhibit_i,
   input wire logic over_temp_i,
   input wire logic temp_release_i,
   output logic [NCH-1:0] drive_o,
   output logic thermal_off_o,
   output logic por_busy_o
);
   logic [CNT_W-1:0] chop_r, chop_nxt;
   logic set_odd_r, set_odd_nxt, set_even_r, set_even_nxt;
   logic hot_r, hot_nxt;
   logic [4:0] por_r, por_nxt;
   logic por_done;
   logic [NCH-1:0] trip_q_r, drive_raw;
   logic allow;

   // free-running chop clock, two phases half a period apart
   always_comb begin
      chop_nxt = (chop_r == CNT_W'(CHOP_CYC - 1)) ? '0 : chop_r + CNT_W'(1);
      set_odd_nxt = (chop_r == '0);
      set_even_nxt = (chop_r == CNT_W'(CHOP_CYC / 2));
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         chop_r <= '0;
         set_odd_r <= 1'b0;
         set_even_r <= 1'b0;
      end else begin
         chop_r <= chop_nxt;
         set_odd_r <= set_odd_nxt;
         set_even_r <= set_even_nxt;
      end
   end

   // thermal latch with hysteresis; shutdown wins over release
   always_comb begin
      hot_nxt = hot_r;
      if (over_temp_i) begin
         hot_nxt = 1'b1;
      end else if (temp_release_i) begin
         hot_nxt = 1'b0;
      end
   end

   // power-on hold counter
   always_comb begin
      por_done = (por_r == 5'(POR_CYC));
      por_nxt = por_done ? por_r : por_r + 5'h01;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         hot_r <= 1'b0;
         por_r <= 5'h00;
      end else begin
         hot_r <= hot_nxt;
         por_r <= por_nxt;
      end
   end

   // trip registered once; total latency stays within the delay budget
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         trip_q_r <= '0;
      end else begin
         trip_q_r <= trip_i;
      end
   end

   assign allow = print_en_i && !hot_r && !over_temp_i && por_done;

   // channel index k is output k+1: even index = odd-numbered output
   for (genvar k = 0; k < NCH; k++) begin : g_ch
      scc_chan #(.LOCK_W(8)) u_ch (
         .clk_i(clk_i),
         .nrst_i(nrst_i),
         .set_i((k % 2 == 0) ? set_odd_r : set_even_r),
         .trip_i(trip_q_r[k]),
         .allow_i(allow && latch_data_i[k]),
         .inhibit_i(chop_inhibit_i),
         .drive_o(drive_raw[k])
      );
   end

   // outputs straight from flops
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         drive_o <= '0;
         thermal_off_o <= 1'b0;
         por_busy_o <= 1'b1;
      end else begin
         drive_o <= (hot_r || over_temp_i) ? '0 : drive_raw;
         thermal_off_o <= hot_nxt;
         por_busy_o <= !por_done;
      end
   end
endmodule
`default_nettype wire

// ---- verif/scc_top_props.sv ----
`default_nettype none
// watches the top ports; output 1 stands for the odd group, output 2 for the even
module scc_top_props
   import scc_pkg::*;
#(parameter int unsigned NCH = CHANNELS) (
   input wire logic clk_i, input wire logic nrst_i, input wire logic [NCH-1:0] latch_data_i,
   input wire logic print_en_i, input wire logic [NCH-1:0] trip_i, input wire logic chop_inhibit_i,
   input wire logic over_temp_i, input wire logic temp_release_i, input wire logic [NCH-1:0] drive_o,
   input wire logic thermal_off_o, input wire logic por_busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic [15:0] on_r, on_nxt;
   // on time of output 1, cleared while off
   always_comb on_nxt = drive_o[0] ? on_r + 16'h1 : 16'h0;
   always_ff @(posedge clk_i) on_r <= on_nxt;
   // a window close may take two cycles to reach the pins
   a_heat_off: assert property (over_temp_i |=> !drive_o) else $error("hot");
   a_heat_hold: assert property (thermal_off_o && !temp_release_i |=> thermal_off_o) else $error("cool");
   a_por_quiet: assert property (por_busy_o |-> !drive_o) else $error("power-up");
   a_window_off: assert property (!print_en_i [*3] |-> !drive_o) else $error("window");
   // trip flop, latch and output flop, then one more edge before the low is sampled
   a_trip_off: assert property (trip_i[0] && on_r > 16'hA0 && !chop_inhibit_i |-> ##[1:4] !drive_o[0])
      else $error("trip");
   a_stay_off: assert property ($fell(drive_o[0]) && print_en_i |=> !drive_o[0] [*8]) else $error("early");
   a_group_split: assert property ($rose(drive_o[0]) && !chop_inhibit_i |-> !$rose(drive_o[1]))
      else $error("groups");
   a_lock_min: assert property ($fell(drive_o[0]) && print_en_i && latch_data_i[0] && !thermal_off_o
      |-> on_r >= 16'h96) else $error("lockout");
   a_inhibit_on: assert property (drive_o[0] && chop_inhibit_i && print_en_i && latch_data_i[0] && !over_temp_i
      |=> drive_o[0]) else $error("inhibit");
endmodule
bind scc_top scc_top_props #(.NCH(NCH)) u_props (.*);
`default_nettype wire

// ---- verif/scc_load.sv ----
`default_nettype none
// loads: sense trips RISE cycles into a drive; spk_i forces a false trip
module scc_load #(parameter int RISE = 200) (input wire logic clk_i, input wire logic [8:0] drv_i,
   input wire logic spk_i, output var logic [8:0] trip_o = 9'h000);
   int amp [9];
   // current drops at once when undriven, so no trip lingers to the next set
   always @(posedge clk_i)
      for (int k = 0; k < 9; k++) begin
         amp[k] <= drv_i[k] ? amp[k] + 1 : 0;
         trip_o[k] <= drv_i[k] && amp[k] >= RISE || spk_i;
      end
endmodule
`default_nettype wire

// ---- verif/scc_top_tb.sv ----
`default_nettype none
module scc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, nrst_i = 1'b0, win = 1'b1, inh = 1'b0, hot = 1'b0, cool = 1'b0, spk = 1'b0;
   // bit 8 stands for the looped-back ninth channel input, always loaded high here
   logic [8:0] dat = 9'h1FF, trip, drv;
   // one part of a chained head would load eight channels; this bench drives a single nine-channel part
   logic toff, busy;
   int n_fail = 0, comparisons = 0, cyc = 0;
   initial forever #5 clk_i = ~clk_i;
   scc_top u_dut (.clk_i, .nrst_i, .latch_data_i(dat), .print_en_i(win), .trip_i(trip), .chop_inhibit_i(inh),
      .over_temp_i(hot), .temp_release_i(cool), .drive_o(drv), .thermal_off_o(toff), .por_busy_o(busy));
   scc_load u_load (.clk_i, .drv_i(drv), .spk_i(spk), .trip_o(trip));
   // inputs move 1 ns after the edge
   task automatic step(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(logic [8:0] got, logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %0t %h %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("n_fail %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard; the run needs about 2500 cycles
   always @(posedge clk_i)
      if (++cyc == 6000) begin
         n_fail++;
         complete_run();
      end
   // next turn-on of output 1
   task automatic up0();
      repeat (1100) if (drv[0] === 1'b1) step(1);
      repeat (1100) if (drv[0] !== 1'b1) step(1);
   endtask
   // odd group on, false trip in lockout, real trip, even group half a period on
   task automatic t_chop();
      chk({busy, drv[7:0]}, 9'h100);
      up0();
      chk({busy, drv[7:0]}, 9'h055);
      chk(drv, 9'h155);
      spk = 1'b1;
      step(100);
      spk = 1'b0;
      chk(drv, 9'h155);
      step(200);
      chk(drv, 9'h000);
      step(210);
      chk(drv, 9'h0AA);
      step(500);
      chk(drv, 9'h155);
   endtask
   // inhibit holds outputs on; heat forces them off until release
   task automatic t_hold();
      inh = 1'b1;
      dat = 9'h1F1;
      step(300);
      chk(drv, 9'h1F1);
      hot = 1'b1;
      step(2);
      chk({toff, drv[7:0]}, 9'h100);
      hot = 1'b0;
      step(20);
      chk({toff, drv[7:0]}, 9'h100);
      cool = 1'b1;
      step(5);
      chk({toff, drv[7:0]}, 9'h0F1);
      win = 1'b0;
      step(5);
      chk(drv, 9'h000);
   endtask
   initial begin
      step(6);
      nrst_i = 1'b1;
      t_chop();
      t_hold();
      complete_run();
   end
endmodule
`default_nettype wire
